// ---- astr_pkg.sv ----
package astr_pkg;
	// register map, byte addresses
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFF_RX_SC = 6'h00;
	localparam logic [5:0] OFF_TX_BUF = 6'h04;
	localparam logic [5:0] OFF_TX_SC = 6'h08;
	localparam logic [5:0] OFF_BAUD_C = 6'h0C;
	localparam logic [5:0] OFF_DIV_HI = 6'h10;
	localparam logic [5:0] OFF_DIV_LO = 6'h14;
	localparam logic [5:0] OFF_RX_BUF = 6'h18;
	localparam logic [5:0] OFF_PFLAG = 6'h1C;
	localparam logic [5:0] OFF_PEN = 6'h20;
	localparam logic [5:0] OFF_INTC = 6'h24;
	// serial_rx_status_ctrl fields
	localparam int B_PORT_EN = 7;
	localparam int B_RX_NINE_EN = 6;
	localparam int B_CONT_RX = 4;
	localparam int B_ADDR_DET = 3;
	localparam int B_FRAME_ERR = 2;
	localparam int B_OVERRUN = 1;
	localparam int B_RX_NINE_BIT = 0;
	// serial_tx_status_ctrl fields
	localparam int B_TX_NINE_EN = 6;
	localparam int B_TX_EN = 5;
	localparam int B_CLOCKED = 4;
	localparam int B_HIGH_SPEED = 2;
	localparam int B_SHIFT_EMPTY = 1;
	localparam int B_TX_NINE_BIT = 0;
	// baud_control, flag, enable and int control fields
	localparam int B_WIDE_DIV = 3;
	localparam int B_RX_FLAG = 5;
	localparam int B_TX_FLAG = 4;
	localparam int B_GLOBAL_IE = 7;
	localparam int B_PERIPH_IE = 6;
	// reset values and bus answers
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic LINE_IDLE = 1'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// timing counts
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [3:0] LAST_BIT8 = 4'h7;
	localparam logic [3:0] LAST_BIT9 = 4'h8;
	localparam logic [1:0] PRE_LAST = 2'h3;
	localparam int FAST_SHIFT = 2;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_START = 2'b01,
		TX_DATA = 2'b10,
		TX_STOP = 2'b11
	} astr_tx_state_t;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} astr_rx_state_t;
endpackage

// ---- astr_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module astr_sync (
	// system
	input wire logic mclk,
	input wire logic rst_n,
	// pin in, synchronised out
	input wire logic pinIn,
	output logic pinSync
);
	import astr_pkg::*;
	logic meta_q;
	logic sync_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= LINE_IDLE;
			sync_q <= LINE_IDLE;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
		end
	end
	assign pinSync = sync_q;
endmodule
`default_nettype wire

// ---- astr_baud_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
module astr_baud_gen (
	// system
	input wire logic mclk,
	input wire logic rst_n,
	// configuration
	input wire logic run,
	input wire logic [15:0] divisor,
	input wire logic wide,
	input wire logic highSpeed,
	// one pulse per sixteenth of a bit
	output logic tick
);
	import astr_pkg::*;
	logic [15:0] span;
	logic [1:0] pre_q;
	logic [15:0] cnt_q;
	logic tick_q;
	logic step;
	always_comb begin
		span = wide ? divisor : {8'h00, divisor[7:0]};
		if (wide && highSpeed) begin
			span = span >> FAST_SHIFT;
		end
	end
	// slow 8-bit mode divides by four before the divisor
	assign step = wide || highSpeed || (pre_q == PRE_LAST);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 2'h0;
			cnt_q <= 16'h0000;
			tick_q <= 1'h0;
		end else if (!run) begin
			pre_q <= 2'h0;
			cnt_q <= 16'h0000;
			tick_q <= 1'h0;
		end else begin
			pre_q <= pre_q + 2'h1;
			tick_q <= 1'h0;
			if (step) begin
				if (cnt_q >= span) begin
					cnt_q <= 16'h0000;
					tick_q <= 1'h1;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end
	assign tick = tick_q;
endmodule
`default_nettype wire

// ---- astr_top.sv ----
// Overview of operation
// - shift register loads only after stop bit
// - transfer takes one cycle, sets buffer-empty flag
// - flag set always; only buffer write clears
// - cleared flag valid second cycle after write
// - tx interrupt passes only when enabled
// - shift-empty status read-only, no interrupt
// - setting transmit enable sets buffer-empty flag
// - buffer write starts transmission when enabled
// - ninth-bit enable sends ninth data bit
// - async when clocked-mode clear, port enabled
// - bit rate from divisor and select bits
// - receiver samples at sixteen times bit rate
// - receive only while continuous receive enabled
// - completed character sets flag, may interrupt
// - ninth bit and errors readable in status
// - eight data bits read from receive buffer
// - clearing continuous receive clears errors
// - address detect withholds ordinary characters
// - interrupts need global and peripheral enables
// - frame: start, 8/9 bits lsb first, stop
`timescale 1ns/10ps
`default_nettype none
module astr_top (
	// system
	input wire logic mclk,
	input wire logic rst_n,
	// axi4-lite write address
	input wire logic [astr_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [astr_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// serial line
	input wire logic rxPin,
	output logic txPin,
	// processor interrupt
	output logic serIrq
);
	import astr_pkg::*;

	function automatic logic regMapped(input logic [ADDR_W-1:0] a);
		case (a)
			OFF_RX_SC, OFF_TX_BUF, OFF_TX_SC, OFF_BAUD_C, OFF_DIV_HI: regMapped = 1'h1;
			OFF_DIV_LO, OFF_RX_BUF, OFF_PFLAG, OFF_PEN, OFF_INTC: regMapped = 1'h1;
			default: regMapped = 1'h0;
		endcase
	endfunction

	function automatic logic [3:0] lastBit(input logic nine);
		lastBit = nine ? LAST_BIT9 : LAST_BIT8;
	endfunction

	logic awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
	logic [ADDR_W-1:0] awAddr_q;
	logic [7:0] wByte_q, rData_q, rdVal;
	logic wLane_q;
	logic [1:0] bResp_q, rResp_q;
	logic wrGo, wrEn, rdGo, rdRxBuf;
	logic portEn_q, rxNinthEn_q, contRx_q, addrDet_q, frameErr_q, overrun_q, rxNinthBit_q;
	logic txNinthEn_q, tx_enable_q, clocked_q, highSpeed_q, txNinth_q, wideDiv_q;
	logic [7:0] divHi_q, divLo_q, txBuf_q, rxBuf_q;
	logic txIe_q, rxIe_q, globalIe_q, periphIe_q, serIrq_q;
	logic txBufFull_q, txFlag_q, txShiftEmpty_q, txNine_q, txPin_q, rxFull_q, rxPrev_q;
	logic asyncOn, txRun, rxRun, txLoad, bufWrite, txEnSet, tick, rxSync;
	logic rxDone, rxNinthIn, rxKeep;
	logic [7:0] rxData;
	logic [8:0] txShift_q, rxShift_q;
	logic [3:0] txCnt_q, txIdx_q, rxCnt_q, rxIdx_q;
	astr_tx_state_t txState_q;
	astr_rx_state_t rxState_q;

	////////////////////////////////////////////////////////////////////////////
	// bus slave
	assign wrGo = !awReady_q && !wReady_q && !bValid_q;
	assign wrEn = wrGo && wLane_q && regMapped(awAddr_q);
	assign rdGo = arvalid && arReady_q;
	assign rdRxBuf = rdGo && (araddr == OFF_RX_BUF);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			awReady_q <= 1'h1;
			awAddr_q <= '0;
		end else if (awvalid && awReady_q) begin
			awAddr_q <= awaddr;
			awReady_q <= 1'h0;
		end else if (wrGo) begin
			awReady_q <= 1'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wReady_q <= 1'h1;
			wByte_q <= REG_RST;
			wLane_q <= 1'h0;
		end else if (wvalid && wReady_q) begin
			wByte_q <= wdata[7:0];
			wLane_q <= wstrb[0];
			wReady_q <= 1'h0;
		end else if (wrGo) begin
			wReady_q <= 1'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bValid_q <= 1'h0;
			bResp_q <= RESP_OKAY;
		end else if (wrGo) begin
			bValid_q <= 1'h1;
			bResp_q <= regMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (bValid_q && bready) begin
			bValid_q <= 1'h0;
		end
	end

	always_comb begin
		rdVal = REG_RST;
		case (araddr)
			OFF_RX_SC: begin
				rdVal[B_PORT_EN] = portEn_q;
				rdVal[B_RX_NINE_EN] = rxNinthEn_q;
				rdVal[B_CONT_RX] = contRx_q;
				rdVal[B_ADDR_DET] = addrDet_q;
				rdVal[B_FRAME_ERR] = frameErr_q;
				rdVal[B_OVERRUN] = overrun_q;
				rdVal[B_RX_NINE_BIT] = rxNinthBit_q;
			end
			OFF_TX_BUF: rdVal = txBuf_q;
			OFF_TX_SC: begin
				rdVal[B_TX_NINE_EN] = txNinthEn_q;
				rdVal[B_TX_EN] = tx_enable_q;
				rdVal[B_CLOCKED] = clocked_q;
				rdVal[B_HIGH_SPEED] = highSpeed_q;
				rdVal[B_SHIFT_EMPTY] = txShiftEmpty_q;
				rdVal[B_TX_NINE_BIT] = txNinth_q;
			end
			OFF_BAUD_C: rdVal[B_WIDE_DIV] = wideDiv_q;
			OFF_DIV_HI: rdVal = divHi_q;
			OFF_DIV_LO: rdVal = divLo_q;
			OFF_RX_BUF: rdVal = rxBuf_q;
			OFF_PFLAG: begin
				rdVal[B_RX_FLAG] = rxFull_q;
				rdVal[B_TX_FLAG] = txFlag_q;
			end
			OFF_PEN: begin
				rdVal[B_RX_FLAG] = rxIe_q;
				rdVal[B_TX_FLAG] = txIe_q;
			end
			OFF_INTC: begin
				rdVal[B_GLOBAL_IE] = globalIe_q;
				rdVal[B_PERIPH_IE] = periphIe_q;
			end
			default: rdVal = REG_RST;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			arReady_q <= 1'h1;
			rValid_q <= 1'h0;
			rData_q <= REG_RST;
			rResp_q <= RESP_OKAY;
		end else if (rdGo) begin
			arReady_q <= 1'h0;
			rValid_q <= 1'h1;
			rData_q <= rdVal;
			rResp_q <= regMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rValid_q && rready) begin
			rValid_q <= 1'h0;
			arReady_q <= 1'h1;
		end
	end

	assign awready = awReady_q;
	assign wready = wReady_q;
	assign bvalid = bValid_q;
	assign bresp = bResp_q;
	assign arready = arReady_q;
	assign rvalid = rValid_q;
	assign rresp = rResp_q;
	assign rdata = {24'h000000, rData_q};

	////////////////////////////////////////////////////////////////////////////
	// control registers
	assign bufWrite = wrEn && (awAddr_q == OFF_TX_BUF);
	assign txEnSet = wrEn && (awAddr_q == OFF_TX_SC) && wByte_q[B_TX_EN] && !tx_enable_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{portEn_q, rxNinthEn_q, contRx_q, addrDet_q} <= 4'h0;
			{txNinthEn_q, tx_enable_q, clocked_q, highSpeed_q, txNinth_q} <= 5'h00;
			{wideDiv_q, txIe_q, rxIe_q, globalIe_q, periphIe_q} <= 5'h00;
			divHi_q <= REG_RST;
			divLo_q <= REG_RST;
		end else if (wrEn) begin
			case (awAddr_q)
				OFF_RX_SC: begin
					portEn_q <= wByte_q[B_PORT_EN];
					rxNinthEn_q <= wByte_q[B_RX_NINE_EN];
					contRx_q <= wByte_q[B_CONT_RX];
					addrDet_q <= wByte_q[B_ADDR_DET];
				end
				OFF_TX_SC: begin
					txNinthEn_q <= wByte_q[B_TX_NINE_EN];
					tx_enable_q <= wByte_q[B_TX_EN];
					clocked_q <= wByte_q[B_CLOCKED];
					highSpeed_q <= wByte_q[B_HIGH_SPEED];
					txNinth_q <= wByte_q[B_TX_NINE_BIT];
				end
				OFF_BAUD_C: wideDiv_q <= wByte_q[B_WIDE_DIV];
				OFF_DIV_HI: divHi_q <= wByte_q;
				OFF_DIV_LO: divLo_q <= wByte_q;
				OFF_PEN: begin
					rxIe_q <= wByte_q[B_RX_FLAG];
					txIe_q <= wByte_q[B_TX_FLAG];
				end
				OFF_INTC: begin
					globalIe_q <= wByte_q[B_GLOBAL_IE];
					periphIe_q <= wByte_q[B_PERIPH_IE];
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// baud ticks and receive pin
	assign asyncOn = portEn_q && !clocked_q;
	assign txRun = asyncOn && tx_enable_q;
	assign rxRun = asyncOn && contRx_q;

	astr_baud_gen u_baud (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(txRun || rxRun),
		.divisor({divHi_q, divLo_q}),
		.wide(wideDiv_q),
		.highSpeed(highSpeed_q),
		.tick(tick)
	);

	astr_sync u_rxSync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pinIn(rxPin),
		.pinSync(rxSync)
	);

	////////////////////////////////////////////////////////////////////////////
	// transmit buffer and flag
	assign txLoad = txRun && txBufFull_q && (txState_q == TX_IDLE);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txBuf_q <= REG_RST;
			txBufFull_q <= 1'h0;
		end else if (bufWrite) begin
			txBuf_q <= wByte_q;
			txBufFull_q <= 1'h1;
		end else if (txLoad) begin
			txBufFull_q <= 1'h0;
		end
	end

	// set wins over the clearing write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txFlag_q <= 1'h0;
		end else if (txLoad || txEnSet) begin
			txFlag_q <= 1'h1;
		end else if (bufWrite) begin
			txFlag_q <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit shifter
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txState_q <= TX_IDLE;
			txShift_q <= 9'h000;
			txNine_q <= 1'h0;
			txCnt_q <= 4'h0;
			txIdx_q <= 4'h0;
			txShiftEmpty_q <= 1'h1;
		end else if (!txRun) begin
			txState_q <= TX_IDLE;
			txCnt_q <= 4'h0;
			txShiftEmpty_q <= 1'h1;
		end else if (txState_q == TX_IDLE) begin
			if (txLoad) begin
				txShift_q <= {txNinth_q, txBuf_q};
				txNine_q <= txNinthEn_q;
				txIdx_q <= 4'h0;
				txCnt_q <= 4'h0;
				txShiftEmpty_q <= 1'h0;
				txState_q <= TX_START;
			end
		end else if (tick) begin
			txCnt_q <= txCnt_q + 4'h1;
			if (txCnt_q == TICK_LAST) begin
				case (txState_q)
					TX_START: txState_q <= TX_DATA;
					TX_DATA: begin
						txShift_q <= {1'h0, txShift_q[8:1]};
						txIdx_q <= txIdx_q + 4'h1;
						if (txIdx_q == lastBit(txNine_q)) begin
							txState_q <= TX_STOP;
						end
					end
					default: begin
						txState_q <= TX_IDLE;
						txShiftEmpty_q <= 1'h1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txPin_q <= LINE_IDLE;
		end else if (txState_q == TX_DATA) begin
			txPin_q <= txShift_q[0];
		end else begin
			txPin_q <= (txState_q != TX_START);
		end
	end
	assign txPin = txPin_q;

	////////////////////////////////////////////////////////////////////////////
	// receive shifter, sixteen ticks per bit
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxPrev_q <= LINE_IDLE;
		end else begin
			rxPrev_q <= rxSync;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxState_q <= RX_IDLE;
			rxShift_q <= 9'h000;
			rxCnt_q <= 4'h0;
			rxIdx_q <= 4'h0;
		end else if (!rxRun) begin
			rxState_q <= RX_IDLE;
			rxCnt_q <= 4'h0;
		end else if (rxState_q == RX_IDLE) begin
			if (rxPrev_q && !rxSync) begin
				rxState_q <= RX_START;
				rxCnt_q <= 4'h0;
			end
		end else if (tick) begin
			rxCnt_q <= rxCnt_q + 4'h1;
			case (rxState_q)
				RX_START: begin
					if (rxCnt_q == TICK_MID) begin
						rxCnt_q <= 4'h0;
						rxIdx_q <= 4'h0;
						rxState_q <= rxSync ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rxCnt_q == TICK_LAST) begin
						rxShift_q <= {rxSync, rxShift_q[8:1]};
						rxIdx_q <= rxIdx_q + 4'h1;
						if (rxIdx_q == lastBit(rxNinthEn_q)) begin
							rxState_q <= RX_STOP;
						end
					end
				end
				default: begin
					if (rxCnt_q == TICK_LAST) begin
						rxState_q <= RX_IDLE;
					end
				end
			endcase
		end
	end

	assign rxDone = (rxState_q == RX_STOP) && tick && (rxCnt_q == TICK_LAST);
	assign rxData = rxNinthEn_q ? rxShift_q[7:0] : rxShift_q[8:1];
	assign rxNinthIn = rxNinthEn_q && rxShift_q[8];
	assign rxKeep = !addrDet_q || rxNinthIn;

	////////////////////////////////////////////////////////////////////////////
	// receive buffer, flag and errors
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxFull_q <= 1'h0;
			rxBuf_q <= REG_RST;
			rxNinthBit_q <= 1'h0;
			frameErr_q <= 1'h0;
			overrun_q <= 1'h0;
		end else begin
			if (rxDone && rxKeep && !rxFull_q && !overrun_q) begin
				rxFull_q <= 1'h1;
				rxBuf_q <= rxData;
				rxNinthBit_q <= rxNinthIn;
				frameErr_q <= !rxSync;
			end else if (rdRxBuf) begin
				rxFull_q <= 1'h0;
			end
			if (rxDone && rxKeep && rxFull_q) begin
				overrun_q <= 1'h1;
			end
			if (!contRx_q) begin
				frameErr_q <= 1'h0;
				overrun_q <= 1'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt request
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			serIrq_q <= 1'h0;
		end else begin
			serIrq_q <= globalIe_q && periphIe_q &&
				((txFlag_q && txIe_q) || (rxFull_q && rxIe_q));
		end
	end
	assign serIrq = serIrq_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_startBit;
		(txState_q == TX_START) ##1 !txPin_q;
	endsequence
	property p_load_frame;
		txLoad |=> s_startBit;
	endproperty
	a_load_frame: assert property (p_load_frame) else $error("no start bit after load");
	property p_load_after_stop;
		txLoad |-> (txState_q == TX_IDLE) && txShiftEmpty_q;
	endproperty
	a_load_after_stop: assert property (p_load_after_stop) else $error("load while busy");
	property p_load_flag;
		txLoad |=> txFlag_q && !txShiftEmpty_q;
	endproperty
	a_load_flag: assert property (p_load_flag) else $error("load did not set flag");
	property p_flag_hold;
		txFlag_q && !bufWrite |=> txFlag_q;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost without write");
	property p_write_clear;
		bufWrite && !txLoad && !txEnSet |=> !txFlag_q ##1 (txFlag_q != txBufFull_q);
	endproperty
	a_write_clear: assert property (p_write_clear) else $error("write did not clear");
	property p_en_flag;
		txEnSet |=> txFlag_q;
	endproperty
	a_en_flag: assert property (p_en_flag) else $error("enable did not set flag");
	property p_idle_high;
		(txState_q == TX_IDLE) [*2] |-> txPin_q;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line low while idle");
	property p_irq_gate;
		!(globalIe_q && periphIe_q) |=> !serIrq_q;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");
	property p_tx_irq;
		globalIe_q && periphIe_q && txIe_q && txFlag_q |=> serIrq_q;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx interrupt missing");
	property p_rx_off;
		!contRx_q |=> (rxState_q == RX_IDLE) && !frameErr_q && !overrun_q;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receiver not stopped");
	property p_addr_drop;
		rxDone && addrDet_q && !rxNinthIn && !rxFull_q |=> !rxFull_q;
	endproperty
	a_addr_drop: assert property (p_addr_drop) else $error("data char not dropped");
	property p_rx_flag;
		rxDone && !addrDet_q && !rxFull_q && !overrun_q |=> rxFull_q;
	endproperty
	a_rx_flag: assert property (p_rx_flag) else $error("receive flag missing");
endmodule
`default_nettype wire

// ---- astr_remote_node.sv ----
`timescale 1ns/10ps
`default_nettype none
module astr_remote_node #(
	parameter int BIT_CLKS = 32
) (
	// system
	input wire logic mclk,
	// serial lines
	input wire logic txLine,
	output logic rxLine,
	// receive setup
	input wire logic nineBits
);
	logic [8:0] gotQ[$];
	// bit length in clocks, retuned by the bench per baud setting
	int bitClks = BIT_CLKS;
	initial rxLine = 1'h1;
	////////////////////////////////////////////////////////////////
	// frame out, lsb first, chosen stop level
	task automatic sendFrame(input logic [8:0] d, input logic nine, input logic stop);
		logic [10:0] f;
		f = {stop, nine ? d[8] : stop, d[7:0], 1'h0};
		for (int i = 0; i < 11; i++) begin
			rxLine <= f[i];
			repeat (bitClks) @(posedge mclk);
		end
		rxLine <= 1'h1;
		repeat (bitClks) @(posedge mclk);
	endtask
	////////////////////////////////////////////////////////////////
	// capture device frames at bit centre
	always begin : capture
		logic [8:0] got;
		int n;
		@(negedge txLine);
		got = '0;
		n = nineBits ? 9 : 8;
		repeat (bitClks / 2) @(posedge mclk);
		for (int i = 0; i <= n; i++) begin
			repeat (bitClks) @(posedge mclk);
			if (i < n) got[i] = txLine;
		end
		// stop level gates the capture
		if (txLine === 1'h1) gotQ.push_back(got);
	end
endmodule
`default_nettype wire

// ---- async_serial_tx_rx_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module async_serial_tx_rx_tb_top;
	import astr_pkg::*;
	logic mclk = 1'h0;
	logic rst_n = 1'h0;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, rxPin, txPin, serIrq, nodeNine;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rr, br;
	logic [8:0] d0, d1;
	int err_total = 0;
	int compares = 0;

	always #12.5 mclk = ~mclk;

	astr_top i_dut (.mclk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .rxPin, .txPin, .serIrq);
	astr_remote_node #(.BIT_CLKS(32)) i_node (.mclk, .txLine(txPin), .rxLine(rxPin),
		.nineBits(nodeNine));
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("counts: %0d compares, %0d mismatches", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			err_total++;
			$display("mismatch at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic testDone(input string s);
		$display("test %s done", s);
	endtask
	function automatic logic [8:0] expRx9(input logic [8:0] d, input logic nine);
		return nine ? d : {1'h0, d[7:0]};
	endfunction
	// tx enable and high speed always on
	function automatic logic [7:0] txSc(input logic nine, input logic b9);
		return {1'h0, nine, 4'h9, 1'h0, b9};
	endfunction
	////////////////////////////////////////////////////////////////
	// bus cycles; handshakes judged at the negedge before the taking edge
	task automatic axiWr(input logic [5:0] a, input logic [7:0] d);
		logic aw, w, b;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		b = 1'h0;
		while (!b) begin
			@(negedge mclk);
			aw = awvalid & awready;
			w = wvalid & wready;
			b = bvalid === 1'h1;
			br = bresp;
			@(posedge mclk);
			if (aw) awvalid <= 1'h0;
			if (w) wvalid <= 1'h0;
		end
		bready <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic axiRd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, rv;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		rv = 1'h0;
		while (!rv) begin
			@(negedge mclk);
			ar = arvalid & arready;
			rv = rvalid === 1'h1;
			d = rdata;
			r = rresp;
			@(posedge mclk);
			if (ar) arvalid <= 1'h0;
		end
		rready <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic rdChk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] w);
		logic [31:0] d;
		logic [1:0] r;
		axiRd(a, d, r);
		check(d & {24'h0, m}, {24'h0, w});
	endtask
	task automatic chkIrq(input logic w);
		@(negedge mclk);
		check(serIrq, w);
		@(posedge mclk);
	endtask
	task automatic waitFrames(input int n);
		for (int t = 0; t < 4000 && i_node.gotQ.size() < n; t++) @(posedge mclk);
		// rest of the stop bit
		repeat (40) @(posedge mclk);
	endtask
	////////////////////////////////////////////////////////////////
	// limit far above the expected run
	initial begin
		repeat (60000) @(posedge mclk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		{awvalid, wvalid, arvalid, bready, rready, nodeNine} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		void'($urandom(32'h00D1500A));
		repeat (12) @(posedge mclk);
		rst_n <= 1'h1;
		@(posedge mclk);
		rdChk(OFF_TX_SC, 8'hFF, 8'h02);
		rdChk(OFF_PFLAG, 8'hFF, 8'h00);
		axiRd(6'h28, rd, rr);
		check(rr, RESP_SLVERR);
		check(rd, 32'h0);
		axiWr(6'h28, 8'hFF);
		check(br, RESP_SLVERR);
		axiWr(OFF_DIV_LO, 8'h01);
		axiWr(OFF_RX_SC, 8'h80);
		axiWr(OFF_TX_SC, txSc(1'h0, 1'h0));
		rdChk(OFF_PFLAG, 8'h10, 8'h10);
		axiWr(OFF_PFLAG, 8'h00);
		check(br, RESP_OKAY);
		rdChk(OFF_PFLAG, 8'h10, 8'h10);
		testDone("setup");
		// back-to-back frames, 8 then 9 bits
		for (int k = 0; k < 4; k++) begin
			d0 = 9'($urandom);
			d1 = 9'($urandom);
			nodeNine <= k[1];
			axiWr(OFF_TX_SC, txSc(k[1], d0[8]));
			axiWr(OFF_TX_BUF, d0[7:0]);
			axiWr(OFF_TX_BUF, d1[7:0]);
			rdChk(OFF_PFLAG, 8'h10, 8'h00);
			rdChk(OFF_TX_SC, 8'h02, 8'h00);
			waitFrames(2);
			check(i_node.gotQ.size(), 2);
			check(i_node.gotQ.pop_front(), expRx9(d0, k[1]));
			check(i_node.gotQ.pop_front(), expRx9({d0[8], d1[7:0]}, k[1]));
			rdChk(OFF_TX_SC, 8'h02, 8'h02);
			rdChk(OFF_PFLAG, 8'h10, 8'h10);
		end
		axiWr(OFF_INTC, 8'hC0);
		axiWr(OFF_PEN, 8'h10);
		chkIrq(1'h1);
		axiWr(OFF_INTC, 8'h40);
		chkIrq(1'h0);
		axiWr(OFF_INTC, 8'hC0);
		axiWr(OFF_PEN, 8'h00);
		chkIrq(1'h0);
		testDone("transmit");
		i_node.sendFrame(9'h0A5, 1'h0, 1'h1);
		rdChk(OFF_PFLAG, 8'h20, 8'h00);
		axiWr(OFF_RX_SC, 8'h90);
		axiWr(OFF_PEN, 8'h20);
		for (int k = 0; k < 3; k++) begin
			d0 = 9'($urandom);
			i_node.sendFrame(d0, 1'h0, 1'h1);
			chkIrq(1'h1);
			rdChk(OFF_RX_SC, 8'h06, 8'h00);
			rdChk(OFF_RX_BUF, 8'hFF, d0[7:0]);
			chkIrq(1'h0);
		end
		// bad stop, then a second character into a full buffer
		i_node.sendFrame(9'h011, 1'h0, 1'h0);
		rdChk(OFF_RX_SC, 8'h04, 8'h04);
		i_node.sendFrame(9'h022, 1'h0, 1'h1);
		rdChk(OFF_RX_SC, 8'h02, 8'h02);
		axiWr(OFF_RX_SC, 8'h80);
		rdChk(OFF_RX_SC, 8'h06, 8'h00);
		rdChk(OFF_RX_BUF, 8'hFF, 8'h11);
		testDone("receive");
		axiWr(OFF_RX_SC, 8'hC0);
		axiWr(OFF_RX_SC, 8'hC8);
		axiWr(OFF_RX_SC, 8'hD8);
		i_node.sendFrame(9'h033, 1'h1, 1'h1);
		rdChk(OFF_PFLAG, 8'h20, 8'h00);
		d0 = {1'h1, 8'($urandom)};
		i_node.sendFrame(d0, 1'h1, 1'h1);
		rdChk(OFF_RX_SC, 8'h01, 8'h01);
		rdChk(OFF_RX_BUF, 8'hFF, d0[7:0]);
		axiWr(OFF_RX_SC, 8'hD0);
		i_node.sendFrame(9'h044, 1'h1, 1'h1);
		rdChk(OFF_RX_SC, 8'h01, 8'h00);
		rdChk(OFF_RX_BUF, 8'hFF, 8'h44);
		testDone("address");
		// slow prescaler, then wide divisor: 64 clocks a bit
		i_node.bitClks = 64;
		nodeNine <= 1'h0;
		axiWr(OFF_TX_SC, 8'h20);
		axiWr(OFF_RX_SC, 8'h90);
		for (int k = 0; k < 2; k++) begin
			axiWr(OFF_BAUD_C, {4'h0, k[0], 3'h0});
			axiWr(OFF_DIV_LO, 8'(k * 3));
			d0 = 9'($urandom);
			axiWr(OFF_TX_BUF, d0[7:0]);
			waitFrames(1);
			check(i_node.gotQ.size(), 1);
			check(i_node.gotQ.pop_front(), {1'h0, d0[7:0]});
			i_node.sendFrame(d0, 1'h0, 1'h1);
			rdChk(OFF_RX_BUF, 8'hFF, d0[7:0]);
		end
		testDone("baud");
		tally_and_finish();
	end
endmodule
`default_nettype wire
